// ### common/scale_if.sv
// carrier between the top and one analog scaling channel
interface scale_if #(parameter int ADC_W = 12);
  logic signed [ADC_W-1:0] code;
  logic signed [15:0]      gain;
  logic [7:0]              deadband;
  logic signed [15:0]      value;
  logic                    in_band;
  modport scaler (input code, input gain, input deadband, output value, output in_band);
  modport user (output code, output gain, output deadband, input value, input in_band);
endinterface

// ### common/torque_cond_consts.svh
// offsets, field positions, reset values and scaling constants of the torque conditioner
`ifndef TORQUE_COND_CONSTS_SVH
`define TORQUE_COND_CONSTS_SVH
`define OFS_CTRL        8'h00
`define OFS_DEADBAND    8'h04
`define OFS_VEL_GAIN    8'h08
`define OFS_TRQ_GAIN    8'h0C
`define OFS_OUT_FUNC    8'h10
`define OFS_RIPPLE      8'h14
`define OFS_STATUS      8'h18
`define OFS_COMMAND     8'h1C
`define CTRL_TYPE_BIT   0
`define CTRL_FA1_LSB    4
`define CTRL_GP_BIT     8
`define RST_TYPE        1'b0
`define RST_FA1         2'h3
`define RST_DEADBAND    8'h00
`define RST_VEL_GAIN    16'sh03E8
`define RST_TRQ_GAIN    16'sh0064
`define RST_OUT_FUNC    14'h0003
`define RST_RIPPLE      9'h000
`define VEL_GAIN_MAX    16'sh2710
`define TRQ_GAIN_MAX    16'sh07D0
`define RIPPLE_MAX      9'h12C
`define OUT_FUNC_MAX    14'h270F
`define FA1_VEL_LIMIT   2'h1
`define FA1_UNUSED      2'h3
`define DIGIT_OPEN_REACH  4'h9
`define DIGIT_CLOSE_REACH 4'h8
`define FULL_SCALE_SHIFT 11
`define MV_PER_CODE_NUM  10'h271
`define MV_PER_CODE_SHIFT 7
`endif

// ### common/torque_cond_pkg.sv
// types shared by the torque conditioner modules
package torque_cond_pkg;
  typedef enum logic [2:0] {
    OUT_GENERAL     = 3'b001,
    OUT_CLOSE_REACH = 3'b010,
    OUT_OPEN_REACH  = 3'b100
  } out_mode_t;
  typedef struct packed {
    logic signed [15:0] value;
    logic               in_band;
  } scaler_state_t;
  typedef struct packed {
    logic reached;
    logic out;
  } reach_state_t;
endpackage

// ### rtl/analog_scaler.sv
// one analog channel: deadband test in millivolts and gain scaling to full scale
`include "torque_cond_consts.svh"
module analog_scaler
  import torque_cond_pkg::*;
#(
  parameter int ADC_W = 12
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  scale_if.scaler   ch
);
  scaler_state_t s_r;
  scaler_state_t s_nxt;
  logic [ADC_W:0]       abs_code;
  logic [ADC_W+10:0]    mv_wide;
  logic signed [ADC_W+15:0] prod;
  logic signed [ADC_W+15:0] scaled;

  // magnitude in mV, then product of code and gain at full scale
  always_comb begin
    s_nxt    = s_r;
    abs_code = ch.code[ADC_W-1] ? (ADC_W+1)'(-$signed({ch.code[ADC_W-1], ch.code}))
                                : (ADC_W+1)'($signed({ch.code[ADC_W-1], ch.code}));
    mv_wide  = ((ADC_W+11)'(abs_code) * (ADC_W+11)'(`MV_PER_CODE_NUM)) >> `MV_PER_CODE_SHIFT;
    prod     = (ADC_W+16)'(ch.code) * (ADC_W+16)'(ch.gain);
    scaled   = prod >>> `FULL_SCALE_SHIFT;
    s_nxt.in_band = (mv_wide <= (ADC_W+11)'(ch.deadband));
    // saturate so a later negation cannot overflow
    if (scaled > 32767)       s_nxt.value = 16'sh7FFF;
    else if (scaled < -32767) s_nxt.value = -16'sh7FFF;
    else                      s_nxt.value = 16'(scaled);
    if (s_nxt.in_band) s_nxt.value = '0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) s_r <= '0;
    else          s_r <= s_nxt;
  end

  assign ch.value   = s_r.value;
  assign ch.in_band = s_r.in_band;
endmodule // analog_scaler

// ### rtl/analog_torque_command_conditioner.sv
// analog torque mode conditioner: AHB-Lite registers, command gating, velocity clamp
`include "torque_cond_consts.svh"
// How it works
// - single-ended deadband 0..255 mV, default zero
// - separate differential deadband 0..255 mV
// - run switch closed: torque follows command
// - run switch open: motor held, no torque
// - direction switch closed reverses rotation
// - input type 0 single-ended, 1 differential
// - first input may act as velocity limit
// - first input function 1..3, default 3 unused
// - velocity gain -100..100 rps at 10 V
// - velocity gain held as rps times 100
// - third output reports torque reached
// - lowest decimal digit selects output behaviour
// - digit 9: closed until reached, then open
// - digit 8: closed when reached, else open
// - digit 3 default: general purpose output
// - reached within ripple tolerance 0.00..3.00 A
// - ripple tolerance held as amps times 100
// - torque gain -20..20 A at 10 V
// - single-ended command on second 12-bit input
module analog_torque_command_conditioner
  import torque_cond_pkg::*;
#(
  parameter int ADC_W = 12
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  input  wire logic [ADC_W-1:0]   first_analog_input,
  input  wire logic [ADC_W-1:0]   second_analog_input,
  input  wire logic               run_stop_switch,
  input  wire logic               direction_switch,
  input  wire logic signed [15:0] actual_torque,
  input  wire logic signed [15:0] motor_speed,
  output logic signed [15:0]      torque_command,
  output logic [15:0]             velocity_limit,
  output logic                    velocity_limit_active,
  output logic                    motor_enable,
  output logic                    torque_reached_output
);
  typedef struct packed {
    logic               input_type_select;
    logic [1:0]         first_input_function;
    logic               gp_out;
    logic [7:0]         single_input_deadband;
    logic [7:0]         differential_deadband;
    logic signed [15:0] velocity_limit_gain;
    logic signed [15:0] torque_gain;
    logic [13:0]        output_function_select;
    logic [8:0]         torque_ripple_tolerance;
    logic               wr_pend;
    logic               addr_hit;
    logic [7:0]         addr;
    logic [31:0]        rdata;
    logic signed [15:0] cmd;
    logic [15:0]        vlim;
    logic               vlim_act;
    logic               enable;
    logic               speed_clamp;
  } top_state_t;

  top_state_t s_r;
  top_state_t s_nxt;

  scale_if #(.ADC_W(ADC_W)) trq_ch ();
  scale_if #(.ADC_W(ADC_W)) vel_ch ();

  logic                    reached;
  logic signed [ADC_W:0]   diff_wide;
  logic signed [ADC_W-1:0] diff_code;
  logic [3:0]              digit;
  out_mode_t               out_mode;
  logic signed [15:0]      vel_value_d;
  logic [15:0]             speed_abs;
  logic signed [15:0]      wr_s16;

  // clamp a signed write into a symmetric legal range
  function automatic logic signed [15:0] clamp_s16(input logic signed [15:0] v,
                                                   input logic signed [15:0] lim);
    logic signed [15:0] r;
    r = v;
    if (v > lim)  r = lim;
    if (v < -lim) r = -lim;
    return r;
  endfunction

  // read mux, taken in the address phase so the data phase needs no wait
  function automatic logic [31:0] read_word(input top_state_t s, input logic [7:0] a,
                                            input logic rch);
    logic [31:0] w;
    w = '0;
    case (a)
      `OFS_CTRL: begin
        w[`CTRL_TYPE_BIT]           = s.input_type_select;
        w[`CTRL_FA1_LSB+1:`CTRL_FA1_LSB] = s.first_input_function;
        w[`CTRL_GP_BIT]             = s.gp_out;
      end
      `OFS_DEADBAND: w[15:0] = {s.differential_deadband, s.single_input_deadband};
      `OFS_VEL_GAIN: w[15:0] = s.velocity_limit_gain;
      `OFS_TRQ_GAIN: w[15:0] = s.torque_gain;
      `OFS_OUT_FUNC: w[13:0] = s.output_function_select;
      `OFS_RIPPLE:   w[8:0]  = s.torque_ripple_tolerance;
      `OFS_STATUS:   w[5:0]  = {s.speed_clamp, s.vlim_act, rch, s.enable,
                                direction_switch, run_stop_switch};
      `OFS_COMMAND:  w       = {s.vlim, s.cmd};
      default:       w       = '0;
    endcase
    return w;
  endfunction

  // differential source is second minus first, saturated to the converter width
  always_comb begin
    diff_wide = (ADC_W+1)'($signed(second_analog_input)) - (ADC_W+1)'($signed(first_analog_input));
    if (diff_wide > $signed((ADC_W+1)'({1'b0, {(ADC_W-1){1'b1}}})))
      diff_code = {1'b0, {(ADC_W-1){1'b1}}};
    else if (diff_wide < $signed((ADC_W+1)'({2'b11, {(ADC_W-1){1'b0}}})))
      diff_code = {1'b1, {(ADC_W-1){1'b0}}};
    else
      diff_code = diff_wide[ADC_W-1:0];
  end

  // torque channel: source and deadband chosen by input type
  assign trq_ch.code     = s_r.input_type_select ? diff_code
                                                  : $signed(second_analog_input);
  assign trq_ch.deadband = s_r.input_type_select ? s_r.differential_deadband
                                                  : s_r.single_input_deadband;
  assign trq_ch.gain     = s_r.torque_gain;

  // velocity channel from the first input; no deadband on the limit
  assign vel_ch.code     = $signed(first_analog_input);
  assign vel_ch.deadband = 8'h00;
  assign vel_ch.gain     = s_r.velocity_limit_gain;

  analog_scaler #(.ADC_W(ADC_W)) u_trq_scale (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ch      (trq_ch.scaler)
  );

  analog_scaler #(.ADC_W(ADC_W)) u_vel_scale (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ch      (vel_ch.scaler)
  );

  // lowest decimal digit picks the output mode; unknown digits stay general purpose
  always_comb begin
    digit = 4'(s_r.output_function_select % 14'h000A);
    case (digit)
      `DIGIT_OPEN_REACH:  out_mode = OUT_OPEN_REACH;
      `DIGIT_CLOSE_REACH: out_mode = OUT_CLOSE_REACH;
      default:            out_mode = OUT_GENERAL;
    endcase
  end

  torque_reach u_reach (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .command    (s_r.cmd),
    .actual     (actual_torque),
    .tolerance  (s_r.torque_ripple_tolerance),
    .mode       (out_mode),
    .gp_value   (s_r.gp_out),
    .reached    (reached),
    .out_closed (torque_reached_output)
  );

  assign vel_value_d = vel_ch.value;
  assign speed_abs   = motor_speed[15] ? 16'(-motor_speed) : 16'(motor_speed);
  assign wr_s16      = $signed(hwdata[15:0]);

  // bus slave, register writes and command gating
  always_comb begin
    s_nxt = s_r;
    // address phase: latch target, fetch read data early
    s_nxt.wr_pend = 1'b0;
    if (hsel && hready && htrans[1]) begin
      s_nxt.wr_pend  = hwrite;
      s_nxt.addr     = haddr[7:0];
      s_nxt.addr_hit = (haddr[31:8] == 24'h000000);
      // a write leaves the last read word standing for slow masters
      if (!hwrite)
        s_nxt.rdata  = (haddr[31:8] != 24'h000000) ? 32'h0000_0000
                       : read_word(s_r, haddr[7:0], reached);
    end
    // data phase write; out-of-range values are pulled to the nearest legal one, but a first input function of 0 is ignored
    if (s_r.wr_pend && s_r.addr_hit) begin
      case (s_r.addr)
        `OFS_CTRL: begin
          s_nxt.input_type_select = hwdata[`CTRL_TYPE_BIT];
          s_nxt.gp_out            = hwdata[`CTRL_GP_BIT];
          if (hwdata[`CTRL_FA1_LSB+1:`CTRL_FA1_LSB] != 2'h0)
            s_nxt.first_input_function = hwdata[`CTRL_FA1_LSB+1:`CTRL_FA1_LSB];
        end
        `OFS_DEADBAND: begin
          s_nxt.single_input_deadband = hwdata[7:0];
          s_nxt.differential_deadband = hwdata[15:8];
        end
        `OFS_VEL_GAIN: s_nxt.velocity_limit_gain = clamp_s16(wr_s16, `VEL_GAIN_MAX);
        `OFS_TRQ_GAIN: s_nxt.torque_gain = clamp_s16(wr_s16, `TRQ_GAIN_MAX);
        `OFS_OUT_FUNC: s_nxt.output_function_select =
          (hwdata[15:0] > 16'(`OUT_FUNC_MAX)) ? `OUT_FUNC_MAX : hwdata[13:0];
        `OFS_RIPPLE: s_nxt.torque_ripple_tolerance =
          (hwdata[15:0] > 16'(`RIPPLE_MAX)) ? `RIPPLE_MAX : hwdata[8:0];
        default: ;
      endcase
    end
    // velocity limit only when the first input is assigned to it
    s_nxt.vlim_act = (s_r.first_input_function == `FA1_VEL_LIMIT);
    s_nxt.vlim     = vel_value_d[15] ? 16'(-vel_value_d) : 16'(vel_value_d);
    // direction switch flips the sign of the conditioned command
    s_nxt.cmd = direction_switch ? 16'(-trq_ch.value) : trq_ch.value;
    // stop pushing further once speed passes the limit in the same direction
    s_nxt.speed_clamp = s_r.vlim_act && (speed_abs > s_r.vlim) && (s_nxt.cmd != 16'sh0000)
                        && (motor_speed[15] == s_nxt.cmd[15]);
    if (s_nxt.speed_clamp) s_nxt.cmd = 16'sh0000;
    // run switch open holds the motor whatever the analog input says
    s_nxt.enable = run_stop_switch;
    if (!run_stop_switch) s_nxt.cmd = 16'sh0000;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r                         <= '0;
      s_r.input_type_select       <= `RST_TYPE;
      s_r.first_input_function    <= `RST_FA1;
      s_r.single_input_deadband   <= `RST_DEADBAND;
      s_r.differential_deadband   <= `RST_DEADBAND;
      s_r.velocity_limit_gain     <= `RST_VEL_GAIN;
      s_r.torque_gain             <= `RST_TRQ_GAIN;
      s_r.output_function_select  <= `RST_OUT_FUNC;
      s_r.torque_ripple_tolerance <= `RST_RIPPLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // zero wait states, always OKAY; hreadyout is a constant flop output
  logic hready_r;
  logic hresp_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hready_r <= 1'b1;
      hresp_r  <= 1'b0;
    end else begin
      hready_r <= 1'b1;
      hresp_r  <= 1'b0;
    end
  end

  assign hreadyout             = hready_r;
  assign hresp                 = hresp_r;
  assign hrdata                = s_r.rdata;
  assign torque_command        = s_r.cmd;
  assign velocity_limit        = s_r.vlim;
  assign velocity_limit_active = s_r.vlim_act;
  assign motor_enable          = s_r.enable;
endmodule // analog_torque_command_conditioner

// ### rtl/torque_reach.sv
// torque reached detection and the polarity of the third general output
module torque_reach
  import torque_cond_pkg::*;
(
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic signed [15:0] command,
  input  wire logic signed [15:0] actual,
  input  wire logic [8:0]         tolerance,
  input  wire out_mode_t          mode,
  input  wire logic               gp_value,
  output logic                    reached,
  output logic                    out_closed
);
  reach_state_t s_r;
  reach_state_t s_nxt;
  logic signed [16:0] err;
  logic [16:0]        err_abs;

  // compare within the ripple band, then pick output polarity
  always_comb begin
    s_nxt   = s_r;
    err     = 17'(command) - 17'(actual);
    err_abs = err[16] ? 17'(-err) : 17'(err);
    s_nxt.reached = (err_abs <= 17'(tolerance));
    case (mode)
      OUT_CLOSE_REACH: s_nxt.out = s_nxt.reached;
      OUT_OPEN_REACH:  s_nxt.out = !s_nxt.reached;
      OUT_GENERAL:     s_nxt.out = gp_value;
      default:         s_nxt.out = gp_value;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) s_r <= '0;
    else          s_r <= s_nxt;
  end

  assign reached    = s_r.reached;
  assign out_closed = s_r.out;
endmodule // torque_reach

// ### verification/analog_torque_command_conditioner_test.sv
// self-checking bench of the analog torque command conditioner
`include "torque_cond_consts.svh"
module analog_torque_command_conditioner_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int ADC_W = 12;
  logic               hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]         htrans = 2'h0;
  logic [2:0]         hsize = 3'h2;
  logic [31:0]        haddr = 32'h0, hwdata = 32'h0, rd;
  logic signed [11:0] set_first = 12'sh000, set_second = 12'sh000;
  logic               set_run = 1'b0, set_dir = 1'b0, set_slow = 1'b0;
  logic signed [15:0] set_speed = 16'sh0000, set_error = 16'sh0000;
  wire logic          hreadyout, hresp, run_stop_switch, direction_switch;
  wire logic          velocity_limit_active, motor_enable, torque_reached_output;
  wire logic [31:0]   hrdata;
  wire logic [11:0]   first_analog_input, second_analog_input;
  wire logic signed [15:0] actual_torque, motor_speed, torque_command;
  wire logic [15:0]   velocity_limit;
  int                 err_count = 0, samples_checked = 0;
  int                 g, db, db2, t, c, want, l, m, r, gp, e, n;
  int                 modes [4] = '{8, 9, 3, 1008};
  logic [31:0]        rst_val [6] = '{32'h30, 32'h0, 32'h3E8, 32'h64, 32'h3, 32'h0};

  analog_torque_command_conditioner #(.ADC_W(ADC_W)) i_analog_torque_command_conditioner (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .first_analog_input, .second_analog_input, .run_stop_switch,
    .direction_switch, .actual_torque, .motor_speed, .torque_command, .velocity_limit,
    .velocity_limit_active, .motor_enable, .torque_reached_output);
  motion_host_model #(.ADC_W(ADC_W)) i_motion_host_model (
    .hclk, .set_first, .set_second, .set_run, .set_dir, .set_slow, .set_speed, .set_error,
    .torque_command, .first_analog_input, .second_analog_input, .run_stop_switch,
    .direction_switch, .motor_speed, .actual_torque);

  // 20 MHz clock
  initial forever #25 hclk = ~hclk;

  task automatic chk(input string what, input logic [31:0] exp_v, input logic [31:0] got);
    samples_checked++;
    if (got !== exp_v) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp_v, got);
    end
  endtask
  // bounded wait for hready; a hang counts an error and ends the run with the results
  task automatic rdy;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 50) begin
      n++;
      @(posedge hclk);
    end
    if (n >= 50) begin
      err_count++;
      results();
    end
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    rdy();
    rd = hrdata;
  endtask
  task automatic results;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // expected channel value: millivolt deadband, then gain over full scale
  function automatic int scale(int cd, int gn, int band);
    return ((((cd < 0) ? -cd : cd) * 625) >>> 7 <= band) ? 0 : (cd * gn) >>> 11;
  endfunction
  function automatic int diff(int a, int b);
    return (a - b > 2047) ? 2047 : (a - b < -2048) ? -2048 : a - b;
  endfunction

  initial begin
    repeat (60000) @(posedge hclk);
    err_count++;
    results();
  end

  initial begin
    void'($urandom(78442));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      ahb(1'b0, 32'(i * 4), 32'h0);
      chk("reset value", rst_val[i], rd);
    end
    ahb(1'b0, 32'h100, 32'h0);
    chk("unmapped read", 32'h0, rd);
    // out-of-range settings clamp to the documented limits
    ahb(1'b1, `OFS_TRQ_GAIN, 32'hBB8);
    ahb(1'b0, `OFS_TRQ_GAIN, 32'h0);
    chk("torque gain clamp", 32'h7D0, rd);
    ahb(1'b1, `OFS_VEL_GAIN, 32'hFFFFB1E0);
    ahb(1'b0, `OFS_VEL_GAIN, 32'h0);
    chk("velocity gain clamp", 32'hD8F0, rd);
    ahb(1'b1, `OFS_RIPPLE, 32'h190);
    ahb(1'b0, `OFS_RIPPLE, 32'h0);
    chk("ripple clamp", 32'h12C, rd);
    ahb(1'b1, `OFS_OUT_FUNC, 32'h2EE0);
    ahb(1'b0, `OFS_OUT_FUNC, 32'h0);
    chk("output function clamp", 32'h270F, rd);
    // random commands alternating single-ended and differential
    set_run <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      t = i % 2;
      g = $urandom_range(4000) - 2000;
      db = $urandom_range(255);
      db2 = $urandom_range(255);
      ahb(1'b1, `OFS_CTRL, 32'h30 | t);
      ahb(1'b1, `OFS_TRQ_GAIN, 32'(g));
      ahb(1'b1, `OFS_DEADBAND, 32'(db2 * 256 + db));
      set_first <= 12'($urandom);
      set_second <= i[2] ? 12'($urandom) : 12'($urandom_range(160) - 80);
      set_dir <= 1'($urandom);
      repeat (5) @(posedge hclk);
      c = t ? diff(set_second, set_first) : set_second;
      want = scale(c, g, t ? db2 : db) * (set_dir ? -1 : 1);
      chk("torque command", 32'(want), 32'(torque_command));
    end
    chk("motor enable", 32'h1, {31'h0, motor_enable});
    set_run <= 1'b0;
    repeat (3) @(posedge hclk);
    chk("stopped command", 32'h0, {31'h0, motor_enable} | 32'(torque_command));
    // first input as velocity limit, clamping torque once speed exceeds it
    ahb(1'b1, `OFS_CTRL, 32'h10);
    ahb(1'b1, `OFS_TRQ_GAIN, 32'h3E8);
    set_run <= 1'b1;
    set_dir <= 1'b0;
    set_second <= 12'sh400;
    for (int i = 0; i < 10; i++) begin
      g = $urandom_range(20000) - 10000;
      ahb(1'b1, `OFS_VEL_GAIN, 32'(g));
      set_first <= 12'($urandom);
      set_speed <= 16'sh0000;
      repeat (5) @(posedge hclk);
      l = scale(set_first, g, 0);
      l = (l < 0) ? -l : l;
      chk("velocity limit", 32'(l), {16'h0, velocity_limit});
      chk("limit active", 32'h1, {31'h0, velocity_limit_active});
      set_speed <= 16'(l + 1);
      repeat (4) @(posedge hclk);
      chk("clamped command", 32'h0, 32'(torque_command));
      set_speed <= 16'(l);
      repeat (4) @(posedge hclk);
      chk("unclamped command", 32'h1F4, 32'(torque_command));
    end
    ahb(1'b1, `OFS_CTRL, 32'h30);
    repeat (3) @(posedge hclk);
    chk("limit inactive", 32'h0, {31'h0, velocity_limit_active});
    // torque-reached output over digits 8, 9 and 3 and random ripple bands
    for (int i = 0; i < 16; i++) begin
      m = modes[i % 4];
      r = $urandom_range(300);
      gp = $urandom_range(1);
      ahb(1'b1, `OFS_CTRL, 32'(32'h30 | gp * 256));
      ahb(1'b1, `OFS_OUT_FUNC, 32'(m));
      ahb(1'b1, `OFS_RIPPLE, 32'(r));
      e = $urandom_range(2 * r + 4) - r - 2;
      set_error <= 16'(e);
      repeat (5) @(posedge hclk);
      want = (e <= r && -e <= r) ? 1 : 0;
      want = (m % 10 == 8) ? want : (m % 10 == 9) ? 1 - want : gp;
      rd = {31'h0, torque_reached_output};
      chk("reached output", 32'(want), rd);
    end
    // slow current: output opens on the step and closes only once current arrives
    set_error <= 16'sh0000;
    ahb(1'b1, `OFS_OUT_FUNC, 32'h8);
    ahb(1'b1, `OFS_RIPPLE, 32'h0);
    set_slow <= 1'b1;
    set_second <= -12'sh400;
    // input, scaler, command, then the reach flop: the open shows on the fourth edge
    repeat (5) @(posedge hclk);
    chk("reach pending", 32'h0, {31'h0, torque_reached_output});
    n = 0;
    while (torque_reached_output !== 1'b1 && n < 400) begin
      @(posedge hclk);
      n++;
    end
    chk("reach after ramp", 32'h1, {31'h0, torque_reached_output});
    results();
  end
endmodule // analog_torque_command_conditioner_test

bind analog_torque_command_conditioner torque_cond_props #(.ADC_W(ADC_W)) i_torque_cond_props (
  .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
  .first_analog_input, .second_analog_input, .run_stop_switch, .torque_command,
  .velocity_limit, .motor_enable);

// ### verification/motion_host_model.sv
// host controller stand-in: analog codes, switches, speed and a lagging motor current
module motion_host_model #(
  parameter int ADC_W = 12
) (
  input  wire logic                    hclk,
  input  wire logic signed [ADC_W-1:0] set_first,
  input  wire logic signed [ADC_W-1:0] set_second,
  input  wire logic                    set_run,
  input  wire logic                    set_dir,
  input  wire logic                    set_slow,
  input  wire logic signed [15:0]      set_speed,
  input  wire logic signed [15:0]      set_error,
  input  wire logic signed [15:0]      torque_command,
  output logic [ADC_W-1:0]             first_analog_input,
  output logic [ADC_W-1:0]             second_analog_input,
  output logic                         run_stop_switch,
  output logic                         direction_switch,
  output logic signed [15:0]           motor_speed,
  output logic signed [15:0]           actual_torque
);
  timeunit 1ns;
  timeprecision 1ns;
  logic signed [15:0] gap;

  initial {first_analog_input, second_analog_input, run_stop_switch, direction_switch,
           motor_speed, actual_torque} = '0;
  assign gap = torque_command - actual_torque;
  // slow mode ramps current 0.08 A a cycle so torque-reached has to wait
  always @(posedge hclk) begin
    first_analog_input  <= set_first;
    second_analog_input <= set_second;
    run_stop_switch     <= set_run;
    direction_switch    <= set_dir;
    motor_speed         <= set_speed;
    if (set_slow)
      actual_torque <= actual_torque + (gap > 16'sh0008 ? 16'sh0008 :
                                        gap < -16'sh0008 ? -16'sh0008 : gap);
    else
      actual_torque <= torque_command + set_error;
  end
endmodule // motion_host_model

// ### verification/torque_cond_props.sv
// concurrent checks on the top ports of the torque conditioner
module torque_cond_props #(
  parameter int ADC_W = 12
) (
  input wire logic               hclk,
  input wire logic               hresetn,
  input wire logic               hsel,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic               hready,
  input wire logic               hreadyout,
  input wire logic               hresp,
  input wire logic [31:0]        hrdata,
  input wire logic [ADC_W-1:0]   first_analog_input,
  input wire logic [ADC_W-1:0]   second_analog_input,
  input wire logic               run_stop_switch,
  input wire logic signed [15:0] torque_command,
  input wire logic [15:0]        velocity_limit,
  input wire logic               motor_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // zero on both inputs can never produce torque in either input mode
  a_zero_band: assert property (
    (first_analog_input == '0 && second_analog_input == '0)[*2] |=> torque_command == 16'sh0000)
    else $error("zero analog input gave a command");
  a_stop_zero: assert property (
    !run_stop_switch |=> torque_command == 16'sh0000 && !motor_enable)
    else $error("open run switch left the motor driven");
  a_enable_rise: assert property (
    $rose(run_stop_switch) |=> motor_enable)
    else $error("closed run switch did not enable the motor");
  a_cmd_range: assert property (
    torque_command <= 16'sh07D0 && torque_command >= -16'sh07D0)
    else $error("torque command beyond full-scale gain");
  a_vlim_range: assert property (
    velocity_limit <= 16'h2710)
    else $error("velocity limit beyond full-scale gain");
  // hrdata must hold between reads, or a slow master would see garbage
  a_read_hold: assert property (
    !(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");
  a_ready_high: assert property (hreadyout)
    else $error("slave inserted a wait state");
  a_okay_resp: assert property (!hresp)
    else $error("slave answered with an error");
endmodule // torque_cond_props
